// ===== hw/pfh_pkg.sv
// Package for the parallel FIFO host port: timing counts and carrier types.
// Assumes a single 200 MHz core clock; the strobes arrive synchronous to it.
package pfh_pkg;
    // =====================================================
    // Timing
    localparam int PFH_CLK_PERIOD_PS = 5000;
    localparam int PFH_FLAG_HOLD_NS = 80;
    // Least time, rounded up to whole cycles
    localparam int PFH_FLAG_HOLD_CYC = (PFH_FLAG_HOLD_NS * 1000 + PFH_CLK_PERIOD_PS - 1) / PFH_CLK_PERIOD_PS;
    localparam int PFH_DATA_W = 8;
    localparam int PFH_DEPTH = 16;
    // Reset values
    localparam logic PFH_FLAG_RST = 1'b1;

    // =====================================================
    // Carriers
    typedef struct packed {
        logic [PFH_DATA_W-1:0] data;
        logic valid;
    } pfh_byte_t;

    // Pin group of one channel's FIFO port
    typedef struct packed {
        logic recv_avail_n;
        logic recv_avail_n_oe;
        logic send_room_n;
        logic send_room_n_oe;
        logic [PFH_DATA_W-1:0] data_out;
        logic data_oe;
        logic pull_low;
    } pfh_pins_t;
endpackage : pfh_pkg

// ===== hw/pfh_fifo.sv
// Small synchronous byte FIFO used for both directions of one channel.
// Assumes one clock; reads and writes are single-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module pfh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Fill side
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    // Drain side
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    input wire logic rd_take,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    import pfh_pkg::*;
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wptr_r;
    logic [AW-1:0] rptr_r;
    logic [$clog2(DEPTH+1)-1:0] cnt_r;
    logic do_wr;
    logic do_rd;

    // =====================================================
    // Handshake
    assign wr_ready = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign rd_valid = (cnt_r != '0);
    assign do_wr = wr_valid && wr_ready;
    assign do_rd = rd_take && rd_valid;
    assign rd_data = mem_r[rptr_r];
    assign level = cnt_r;

    // Storage; no reset needed on the data array
    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem_r[wptr_r] <= wr_data;
        end
    end

    // Pointers and count
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_wr) begin
                wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
            end
            if (do_rd) begin
                rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : pfh_fifo
`default_nettype wire

// ===== hw/pfh_port.sv
// One channel of the byte-wide asynchronous FIFO host port.
// Assumes strobes arrive synchronous to core_clk; the USB side is a plain
// valid/ready byte stream plus suspend, wake and flush signals.
`timescale 1ns/1ps
`default_nettype none
module pfh_port #(
    parameter int DEPTH = pfh_pkg::PFH_DEPTH,
    parameter int HOLD_CYC = pfh_pkg::PFH_FLAG_HOLD_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Host strobes and data bus
    input wire logic fetch_n,
    input wire logic store_n,
    input wire logic flush_or_wake_n,
    input wire logic [pfh_pkg::PFH_DATA_W-1:0] data_in,
    output pfh_pkg::pfh_pins_t pins,
    // USB side receive stream
    input wire logic usb_rx_valid,
    input wire logic [pfh_pkg::PFH_DATA_W-1:0] usb_rx_data,
    output logic usb_rx_ready,
    // USB side transmit stream
    output pfh_pkg::pfh_byte_t usb_tx,
    input wire logic usb_tx_ready,
    // Bus state and configuration
    input wire logic bus_suspended,
    input wire logic wake_enable,
    input wire logic suspend_pull_low,
    output logic resume_req,
    output logic flush_req
);
    import pfh_pkg::*;
    localparam int CW = $clog2(HOLD_CYC + 1);
    localparam int LW = $clog2(DEPTH + 1);

    logic fetch_q_r;
    logic store_q_r;
    logic flush_q_r;
    logic fetch_rise;
    logic store_fall;
    logic store_rise;
    logic flush_fall;
    logic [CW-1:0] rx_hold_r;
    logic [CW-1:0] tx_hold_r;
    logic [CW-1:0] rx_since_r;
    logic [CW-1:0] tx_since_r;
    logic recv_flag_r;
    logic send_flag_r;
    logic out_en_r;
    logic rx_valid;
    logic [PFH_DATA_W-1:0] rx_data;
    logic tx_ready;
    logic [PFH_DATA_W-1:0] rx_byte_r;
    logic resume_r;
    logic flush_r;
    logic [LW-1:0] rx_level;
    logic [LW-1:0] tx_level;
    logic tx_valid;
    logic [PFH_DATA_W-1:0] tx_data;

    // =====================================================
    // Strobe edge detection
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_q_r <= 1'b1;
            store_q_r <= 1'b1;
            flush_q_r <= 1'b1;
        end else begin
            fetch_q_r <= fetch_n;
            store_q_r <= store_n;
            flush_q_r <= flush_or_wake_n;
        end
    end
    assign fetch_rise = fetch_n && !fetch_q_r;
    assign store_fall = !store_n && store_q_r;
    assign store_rise = store_n && !store_q_r;
    // Idle high input never fires; an unused pin must be tied high
    assign flush_fall = !flush_or_wake_n && flush_q_r;

    // =====================================================
    // Buffers, one per direction and private to this channel
    pfh_fifo #(.WIDTH(PFH_DATA_W), .DEPTH(DEPTH)) u_rx_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .wr_valid(usb_rx_valid),
        .wr_data(usb_rx_data),
        .wr_ready(usb_rx_ready),
        .rd_valid(rx_valid),
        .rd_data(rx_data),
        .rd_take(fetch_rise),
        .level(rx_level)
    );

    // Capture on the falling edge; host only stores while room shown
    pfh_fifo #(.WIDTH(PFH_DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .wr_valid(store_fall),
        .wr_data(data_in),
        .wr_ready(tx_ready),
        .rd_valid(tx_valid),
        .rd_data(tx_data),
        .rd_take(usb_tx_ready),
        .level(tx_level)
    );
    assign usb_tx.valid = tx_valid;
    assign usb_tx.data = tx_data;

    // =====================================================
    // Hold-off counted from the strobe's return high, so a long strobe still gets it all
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_hold_r <= '0;
        end else if (fetch_rise) begin
            rx_hold_r <= CW'(HOLD_CYC);
        end else if (rx_hold_r != '0) begin
            rx_hold_r <= rx_hold_r - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_hold_r <= '0;
        end else if (store_rise) begin
            tx_hold_r <= CW'(HOLD_CYC);
        end else if (tx_hold_r != '0) begin
            tx_hold_r <= tx_hold_r - 1'b1;
        end
    end

    // Flags high during a strobe, its hold-off and the first driven cycle,
    // so the host never sees a low flag the moment the drivers turn on
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            recv_flag_r <= PFH_FLAG_RST;
            send_flag_r <= PFH_FLAG_RST;
        end else begin
            recv_flag_r <= !(out_en_r && rx_valid && !fetch_rise && rx_hold_r == '0 && fetch_n);
            send_flag_r <= !(out_en_r && tx_ready && !store_rise && tx_hold_r == '0 && store_n);
        end
    end
    assign pins.recv_avail_n = recv_flag_r;
    assign pins.send_room_n = send_flag_r;

    // Flag drivers stay off while reset holds, pull-up keeps them high
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_en_r <= 1'b0;
        end else begin
            out_en_r <= 1'b1;
        end
    end
    assign pins.recv_avail_n_oe = out_en_r;
    assign pins.send_room_n_oe = out_en_r;

    // =====================================================
    // Read data: registered head byte, bus driven while fetch low
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_byte_r <= '0;
        end else begin
            rx_byte_r <= rx_data;
        end
    end
    assign pins.data_out = rx_byte_r; // bit 0 is least significant
    assign pins.data_oe = out_en_r && !fetch_n;
    // Pull-down option only takes effect in suspend
    assign pins.pull_low = suspend_pull_low && bus_suspended;

    // =====================================================
    // Send-immediate and wake requests, one-cycle pulses
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            resume_r <= 1'b0;
            flush_r <= 1'b0;
        end else begin
            resume_r <= flush_fall && bus_suspended && wake_enable;
            flush_r <= flush_fall && !bus_suspended;
        end
    end
    assign resume_req = resume_r;
    assign flush_req = flush_r;

    // =====================================================
    // Checks
    // Cycles since each strobe cycle ended, saturating; read only by the hold checks
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_since_r <= CW'(HOLD_CYC);
            tx_since_r <= CW'(HOLD_CYC);
        end else begin
            if (fetch_rise) begin
                rx_since_r <= '0;
            end else if (rx_since_r != CW'(HOLD_CYC)) begin
                rx_since_r <= rx_since_r + 1'b1;
            end
            if (store_rise) begin
                tx_since_r <= '0;
            end else if (tx_since_r != CW'(HOLD_CYC)) begin
                tx_since_r <= tx_since_r + 1'b1;
            end
        end
    end

    property p_rx_hold;
        @(posedge core_clk) disable iff (!arst_n)
        !pins.recv_avail_n |-> rx_since_r >= CW'(HOLD_CYC);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive flag fell too soon");

    property p_tx_hold;
        @(posedge core_clk) disable iff (!arst_n)
        !pins.send_room_n |-> tx_since_r >= CW'(HOLD_CYC);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("send flag fell too soon");

    property p_rx_flag;
        @(posedge core_clk) disable iff (!arst_n)
        !pins.recv_avail_n |-> $past(rx_valid);
    endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("receive flag low with empty buffer");

    property p_tx_flag;
        @(posedge core_clk) disable iff (!arst_n)
        (tx_level == LW'(DEPTH)) |=> pins.send_room_n;
    endproperty
    a_tx_flag: assert property (p_tx_flag) else $error("send flag low with full buffer");

    property p_drive;
        @(posedge core_clk) disable iff (!arst_n)
        pins.data_oe == !fetch_n;
    endproperty
    a_drive: assert property (p_drive) else $error("bus drive does not follow fetch");

    property p_advance;
        @(posedge core_clk) disable iff (!arst_n)
        (fetch_rise && rx_valid && !usb_rx_valid) |=> rx_level == $past(rx_level) - 1'b1;
    endproperty
    a_advance: assert property (p_advance) else $error("receive buffer did not advance");

    property p_capture;
        @(posedge core_clk) disable iff (!arst_n)
        (store_fall && tx_ready && !usb_tx_ready) |=> tx_level == $past(tx_level) + 1'b1;
    endproperty
    a_capture: assert property (p_capture) else $error("store byte not captured");

    property p_wake;
        @(posedge core_clk) disable iff (!arst_n)
        (flush_fall && bus_suspended && wake_enable) |=> resume_req && !flush_req;
    endproperty
    a_wake: assert property (p_wake) else $error("resume not requested");

    property p_flush;
        @(posedge core_clk) disable iff (!arst_n)
        (flush_fall && !bus_suspended) |=> flush_req && !resume_req;
    endproperty
    a_flush: assert property (p_flush) else $error("flush not requested");

    property p_flags_on;
        @(posedge core_clk) disable iff (!arst_n)
        $rose(out_en_r) |-> pins.recv_avail_n && pins.send_room_n;
    endproperty
    a_flags_on: assert property (p_flags_on) else $error("flags not high on release");
endmodule : pfh_port
`default_nettype wire

// ===== testbench/pfh_host_model.sv
// Behavioural host for one FIFO channel: strobes the port like a small MCU.
// Assumes the bench resolves the data wire and calls rd, wr and flush.
`timescale 1ns/1ps
`default_nettype none
module pfh_host_model (
    // Clock
    input wire logic core_clk,
    // Flags and bus level from the port
    input wire logic recv_avail_n,
    input wire logic send_room_n,
    input wire logic [pfh_pkg::PFH_DATA_W-1:0] bus,
    // Strobes and data drive
    output logic fetch_n,
    output logic store_n,
    output logic flush_or_wake_n,
    output logic [pfh_pkg::PFH_DATA_W-1:0] dq,
    output logic dq_oe
);
    import pfh_pkg::*;
    localparam int STB = 10; // 50 ns least strobe width
    logic [1:0] rx_s_r = 2'b11;
    logic [1:0] tx_s_r = 2'b11;
    // =====================================
    // Idle levels; unused flush input parked high
    initial begin
        fetch_n = 1'b1;
        store_n = 1'b1;
        flush_or_wake_n = 1'b1;
        dq = 8'h00;
        dq_oe = 1'b0;
    end
    // Flags are async to us, so two flops first
    always @(posedge core_clk) begin
        rx_s_r <= {rx_s_r[0], recv_avail_n};
        tx_s_r <= {tx_s_r[0], send_room_n};
    end
    // =====================================
    // Read: waits up to 200 cycles for a low synced flag, strobe low then high
    task automatic rd(output logic [7:0] b);
        int n;
        n = 0;
        while (rx_s_r[1] !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        fetch_n <= 1'b0;
        repeat (STB) @(posedge core_clk);
        b = bus;
        fetch_n <= 1'b1;
        @(posedge core_clk);
    endtask : rd
    // Write: data set up with the falling store strobe
    task automatic wr(input logic [7:0] b);
        int n;
        n = 0;
        while (tx_s_r[1] !== 1'b0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        dq <= b;
        dq_oe <= 1'b1;
        store_n <= 1'b0;
        repeat (STB) @(posedge core_clk);
        store_n <= 1'b1;
        @(posedge core_clk);
        dq_oe <= 1'b0;
    endtask : wr
    // Short low strobe on the flush/wake input
    task automatic flush();
        @(posedge core_clk);
        flush_or_wake_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        flush_or_wake_n <= 1'b1;
        @(posedge core_clk);
    endtask : flush
endmodule : pfh_host_model
`default_nettype wire

// ===== testbench/pfh_port_tb_top.sv
// Bench for one FIFO host port channel: host model on pins, bench on USB side.
// Assumes a small depth and hold count so fill and hold cases run quickly.
`timescale 1ns/1ps
`default_nettype none
module pfh_port_tb_top;
    import pfh_pkg::*;
    localparam int DEP = 4;
    localparam int HOLD = 4;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic usb_rx_valid = 1'b0;
    logic [PFH_DATA_W-1:0] usb_rx_data = 8'h00;
    logic usb_tx_ready = 1'b0;
    logic bus_suspended = 1'b0;
    logic wake_enable = 1'b0;
    logic suspend_pull_low = 1'b1;
    logic fetch_n, store_n, flush_or_wake_n, dq_oe, usb_rx_ready, resume_req, flush_req;
    logic [PFH_DATA_W-1:0] dq;
    logic [PFH_DATA_W-1:0] bus;
    pfh_pins_t pins;
    pfh_byte_t usb_tx;
    pfh_pins_t pins_b;
    logic b_rx_valid = 1'b0;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int n_res = 0;
    int n_fl = 0;
    logic [7:0] got;
    int n;
    // =====================================
    // Clock, wire resolution and instances
    initial forever #2.5 core_clk = ~core_clk;
    // Weak pull decides the idle bus level
    assign bus = pins.data_oe ? pins.data_out : (dq_oe ? dq : {PFH_DATA_W{~pins.pull_low}});
    pfh_port #(.DEPTH(DEP), .HOLD_CYC(HOLD)) dut (.core_clk(core_clk), .arst_n(arst_n),
        .fetch_n(fetch_n), .store_n(store_n), .flush_or_wake_n(flush_or_wake_n), .data_in(bus),
        .pins(pins), .usb_rx_valid(usb_rx_valid), .usb_rx_data(usb_rx_data),
        .usb_rx_ready(usb_rx_ready), .usb_tx(usb_tx), .usb_tx_ready(usb_tx_ready),
        .bus_suspended(bus_suspended), .wake_enable(wake_enable),
        .suspend_pull_low(suspend_pull_low), .resume_req(resume_req), .flush_req(flush_req));
    pfh_host_model host (.core_clk(core_clk), .recv_avail_n(pins.recv_avail_n),
        .send_room_n(pins.send_room_n), .bus(bus), .fetch_n(fetch_n), .store_n(store_n),
        .flush_or_wake_n(flush_or_wake_n), .dq(dq), .dq_oe(dq_oe));
    // Second channel with idle strobes, to show the channels share no state
    pfh_port #(.DEPTH(DEP), .HOLD_CYC(HOLD)) dut_b (.core_clk(core_clk), .arst_n(arst_n),
        .fetch_n(1'b1), .store_n(1'b1), .flush_or_wake_n(1'b1), .data_in(8'h00),
        .pins(pins_b), .usb_rx_valid(b_rx_valid), .usb_rx_data(8'h3C),
        .usb_rx_ready(), .usb_tx(), .usb_tx_ready(1'b0),
        .bus_suspended(bus_suspended), .wake_enable(wake_enable),
        .suspend_pull_low(suspend_pull_low), .resume_req(), .flush_req());
    // Pulse counters and hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (resume_req === 1'b1) n_res++;
        if (flush_req === 1'b1) n_fl++;
        if (cyc == 5000) begin
            errors++;
            test_done();
        end
    end
    // =====================================
    // Shared helpers
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Cycles until a flag drops, capped at 100
    task automatic hold_len(input bit rx, output int k);
        k = 0;
        while ((rx ? pins.recv_avail_n : pins.send_room_n) !== 1'b0 && k < 100) begin
            @(posedge core_clk);
            k++;
        end
    endtask : hold_len
    task automatic test_done();
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // =====================================
    // Scenarios
    task automatic t_rst();
        chk(pins.recv_avail_n_oe, 1'b0);
        chk(pins.send_room_n_oe, 1'b0);
        chk(pins.recv_avail_n, 1'b1);
        chk(pins.send_room_n, 1'b1);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk(pins.recv_avail_n_oe, 1'b1);
        chk(pins.send_room_n_oe, 1'b1);
        chk(pins.recv_avail_n, 1'b1);
        chk(pins.send_room_n, 1'b0);
    endtask : t_rst
    // Edge bits first, fill until refused, then back-to-back reads
    task automatic t_rx();
        logic [7:0] exp [DEP] = '{8'h01, 8'h80, 8'h5A, 8'hC3};
        for (int i = 0; i < DEP; i++) begin
            @(posedge core_clk);
            usb_rx_valid <= 1'b1;
            usb_rx_data <= exp[i];
        end
        @(posedge core_clk);
        usb_rx_valid <= 1'b0;
        @(posedge core_clk);
        chk(usb_rx_ready, 1'b0);
        for (int i = 0; i < DEP; i++) begin
            host.rd(got);
            chk(got, exp[i]);
            chk(pins_b.recv_avail_n, 1'b1);
            hold_len(1'b1, n);
            chk(n >= HOLD - 1, 1'b1);
            chk(n == 100, i == DEP - 1);
        end
        chk(pins.data_oe, 1'b0);
        // Second channel gets one byte while the first stays empty
        @(posedge core_clk);
        b_rx_valid <= 1'b1;
        @(posedge core_clk);
        b_rx_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(pins_b.recv_avail_n, 1'b0);
        chk(pins.recv_avail_n, 1'b1);
    endtask : t_rx
    // Fill until refused with USB stalled, then drain
    task automatic t_tx();
        logic [7:0] exp [DEP] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
        for (int i = 0; i < DEP; i++) begin
            host.wr(exp[i]);
            hold_len(1'b0, n);
            chk(n >= HOLD - 1, 1'b1);
            chk(n == 100, i == DEP - 1);
        end
        @(posedge core_clk);
        usb_tx_ready <= 1'b1;
        for (int i = 0; i < DEP; i++) begin
            @(negedge core_clk);
            chk(usb_tx.valid, 1'b1);
            chk(usb_tx.data, exp[i]);
        end
        @(negedge core_clk);
        chk(usb_tx.valid, 1'b0);
        hold_len(1'b0, n);
        chk(n < 100, 1'b1);
    endtask : t_tx
    // Suspend, wake enable, expected resume, expected flush
    task automatic t_wake();
        logic [3:0] tbl [3] = '{4'b1110, 4'b0001, 4'b1000};
        int r0;
        int f0;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            bus_suspended <= tbl[i][3];
            wake_enable <= tbl[i][2];
            r0 = n_res;
            f0 = n_fl;
            host.flush();
            repeat (4) @(posedge core_clk);
            chk(n_res - r0, tbl[i][1]);
            chk(n_fl - f0, tbl[i][0]);
            chk(pins.pull_low, tbl[i][3]);
        end
    endtask : t_wake
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        t_rst();
        t_rx();
        t_tx();
        t_wake();
        test_done();
    end
endmodule : pfh_port_tb_top
`default_nettype wire
